// *** logic/ssl_speed_loop.sv ***
// Purpose: velocity loop regulator with apb parameter registers
// Assumes: speed inputs come from logic on pclk; integ_off_pin is asynchronous
// Notes: apb answers with no wait states, read data captured in the setup cycle
// Operation
// [RULE_01] combined integral gain reads coarse times 32 plus fine
// [RULE_02] writing combined gain zeroes coarse and loads fine
// [RULE_03] feedback bandwidth is 100 plus 20 times the setting, 0 to 45
// [RULE_04] mode selects 2nd order, raw, observer or 1st order feedback
// [RULE_05] modes 10 11 12 14 also low-pass the speed command
// [RULE_06] mode bit 7 set gives 8k velocity and 2k position sampling
// [RULE_07] mode bit 7 clear gives 4k velocity and 1k position sampling
// [RULE_08] first-order torque filter set by the output filter setting
// [RULE_09] integral term clamped to the programmed limit, 0 to 32768
// [RULE_10] operation mode -3 uses the speed command with no ramp
// [RULE_11] an input pin switches off integral action while running
// [RULE_12] fine gain weighs one thirty-second of coarse, 0 to 32767
// [RULE_13] coarse integral gain accepts 0 to 1023
// [RULE_14] each sample, torque is gain times error plus clamped integral
`timescale 1ns/1ps
module ssl_speed_loop
  import ssl_pkg::*;
#(
  parameter int SW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic signed [SW-1:0] speed_target,
  input wire logic signed [SW-1:0] speed_raw,
  input wire logic signed [SW-1:0] speed_observer,
  input wire logic integ_off_pin,
  output logic signed [SW-1:0] torque_cmd,
  output logic vel_tick,
  output logic pos_tick
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] kvp;
    logic [15:0] ki_coarse;
    logic [15:0] ki_fine;
    logic [15:0] fb_filt;
    logic [7:0] fb_mode;
    logic [15:0] int_clamp;
    logic [15:0] out_filt;
    logic [7:0] op_mode;
    logic [15:0] ramp_step;
    logic [31:0] rdata;
    logic err;
    logic [11:0] cnt;
    logic [1:0] pdiv;
    logic vtick;
    logic ptick;
    logic sync1;
    logic sync2;
    logic signed [SW-1:0] cmd;
    logic signed [31:0] integ;
    logic signed [SW-1:0] torque_raw;
  } ssl_state_s;
  ssl_state_s r_reg, r_next;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // low two bits must be zero: a misaligned access counts as unmapped
  function automatic logic hit(input logic [31:0] a, input logic [23:0] idx);
    hit = (a[1:0] == 2'b00) && (a[31:2] == {6'h00, idx});
  endfunction

  function automatic logic [15:0] cap16(input logic [31:0] v, input logic [15:0] mx);
    cap16 = (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction

  // symmetric clamp to plus or minus lim
  function automatic logic signed [31:0] sat(input logic signed [47:0] v,
                                             input logic [16:0] lim);
    logic signed [47:0] l;
    l = $signed({31'h0, lim});
    if (v > l) begin
      sat = 32'(l);
    end else if (v < -l) begin
      sat = 32'(-l);
    end else begin
      sat = 32'(v);
    end
  endfunction

  // alpha is bandwidth times 2 pi ts in q16, clipped just below one
  function automatic logic [15:0] bw_coef(input logic [15:0] bw, input logic fast);
    logic [31:0] p;
    p = {16'h0000, bw} * (fast ? 32'(K_FAST) : 32'(K_SLOW));
    bw_coef = (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  // only the listed command-filter codes low-pass the command
  function automatic logic cmd_filt_mode(input logic [6:0] m);
    cmd_filt_mode = (m == 7'd10) || (m == 7'd11) || (m == 7'd12) || (m == 7'd14);
  endfunction

  // ----------------------------------------
  // mode decode and filter coefficients
  // ----------------------------------------
  logic [6:0] mode_val;
  logic cmd_filt_on;
  ssl_fb_e fb_src;
  logic fast;
  logic [15:0] fb_bw;
  logic [15:0] fb_coef;
  logic [15:0] out_coef;
  logic [16:0] ki_mix;
  logic signed [SW-1:0] lpf1_y, lpf2_y, cmdf_y, outf_y;
  logic signed [SW-1:0] fb_val, cmd_val;

  always_comb begin
    fast = r_reg.fb_mode[FAST_RATE_BIT]; // [RULE_06] [RULE_07]
    mode_val = r_reg.fb_mode[6:0];
    cmd_filt_on = cmd_filt_mode(mode_val); // [RULE_05]
    case ((mode_val >= 7'd10) ? 7'(mode_val - 7'd10) : mode_val) // [RULE_04]
      7'd1: fb_src = SSL_FB_RAW;
      7'd2: fb_src = SSL_FB_OBS;
      7'd4: fb_src = SSL_FB_LPF1;
      default: fb_src = SSL_FB_LPF2;
    endcase
    // mode 11 has a raw source and still filters the command
    if (mode_val == 7'd11) begin
      fb_src = SSL_FB_RAW;
    end
    fb_bw = FB_BW_BASE + 16'(r_reg.fb_filt * FB_BW_STEP); // [RULE_03]
    // at the slow rate high bandwidths saturate alpha just below one: filter is close to a pass-through
    fb_coef = bw_coef(fb_bw, fast);
    // setting is the time constant in samples; 0 is treated as 1 (no filter)
    out_coef = (r_reg.out_filt <= 16'h0001) ? 16'hFFFF :
               16'(32'h0000FFFF / {16'h0000, r_reg.out_filt}); // [RULE_08]
    ki_mix = 17'({r_reg.ki_coarse, 5'b00000}) + 17'(r_reg.ki_fine); // [RULE_01] [RULE_12]
    case (fb_src)
      SSL_FB_RAW: fb_val = speed_raw;
      SSL_FB_OBS: fb_val = speed_observer;
      SSL_FB_LPF1: fb_val = lpf1_y;
      default: fb_val = lpf2_y;
    endcase
    cmd_val = cmd_filt_on ? cmdf_y : r_reg.cmd; // [RULE_05]
  end

  // ----------------------------------------
  // filters
  // ----------------------------------------
  // second order is two cascaded first-order stages at the same corner
  ssl_lpf #(.W(SW)) u_fb1 (
    .pclk(pclk),
    .presetn(presetn),
    .en(r_reg.vtick),
    .coef(fb_coef),
    .x(speed_raw),
    .y(lpf1_y)
  );
  ssl_lpf #(.W(SW)) u_fb2 (
    .pclk(pclk),
    .presetn(presetn),
    .en(r_reg.vtick),
    .coef(fb_coef),
    .x(lpf1_y),
    .y(lpf2_y)
  );
  // command filter shares the feedback corner in every command-filter mode
  ssl_lpf #(.W(SW)) u_cmdf (
    .pclk(pclk),
    .presetn(presetn),
    .en(r_reg.vtick),
    .coef(fb_coef),
    .x(r_reg.cmd),
    .y(cmdf_y)
  );
  ssl_lpf #(.W(SW)) u_outf (
    .pclk(pclk),
    .presetn(presetn),
    .en(r_reg.vtick),
    .coef(out_coef),
    .x(r_reg.torque_raw),
    .y(outf_y)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic signed [SW:0] err_v;
  logic signed [47:0] p_term;
  logic signed [47:0] i_sum;
  logic signed [47:0] t_sum;
  logic [11:0] cyc_lim;
  logic signed [SW:0] step_v;
  logic signed [SW:0] gap;
  logic wr;

  always_comb begin
    r_next = r_reg;
    wr = psel && penable && pwrite;
    // ---- apb: read data is taken in the setup cycle
    if (psel && !penable) begin
      r_next.err = 1'b0;
      if (hit(paddr, IDX_KVP)) begin
        r_next.rdata = {16'h0000, r_reg.kvp};
      end else if (hit(paddr, IDX_KI_COARSE)) begin
        r_next.rdata = {16'h0000, r_reg.ki_coarse};
      end else if (hit(paddr, IDX_KI_FINE)) begin
        r_next.rdata = {16'h0000, r_reg.ki_fine};
      end else if (hit(paddr, IDX_KI_MIX)) begin
        r_next.rdata = {15'h0000, ki_mix}; // [RULE_01]
      end else if (hit(paddr, IDX_FB_FILT)) begin
        r_next.rdata = {16'h0000, r_reg.fb_filt};
      end else if (hit(paddr, IDX_FB_MODE)) begin
        r_next.rdata = {24'h000000, r_reg.fb_mode};
      end else if (hit(paddr, IDX_INT_CLAMP)) begin
        r_next.rdata = {16'h0000, r_reg.int_clamp};
      end else if (hit(paddr, IDX_OUT_FILT)) begin
        r_next.rdata = {16'h0000, r_reg.out_filt};
      end else if (hit(paddr, IDX_OP_MODE)) begin
        r_next.rdata = {24'h000000, r_reg.op_mode};
      end else if (hit(paddr, IDX_RAMP_STEP)) begin
        r_next.rdata = {16'h0000, r_reg.ramp_step};
      end else if (hit(paddr, IDX_STATUS)) begin
        r_next.rdata = {28'h0000000, fast, cmd_filt_on, r_reg.sync2, r_reg.ptick};
      end else if (hit(paddr, IDX_TORQUE)) begin
        r_next.rdata = 32'(signed'(outf_y));
      end else begin
        // refused: data reads zero and the write of the same access is dropped
        r_next.rdata = 32'h00000000;
        r_next.err = 1'b1;
      end
    end
    // ---- apb writes, capped registers saturate to the range top, the rest keep the low bits
    if (wr && !r_reg.err) begin
      if (hit(paddr, IDX_KVP)) begin
        r_next.kvp = cap16(pwdata, KVP_MAX);
      end else if (hit(paddr, IDX_KI_COARSE)) begin
        r_next.ki_coarse = cap16(pwdata, KI_COARSE_MAX); // [RULE_13]
      end else if (hit(paddr, IDX_KI_FINE)) begin
        r_next.ki_fine = cap16(pwdata, KI_FINE_MAX); // [RULE_12]
      end else if (hit(paddr, IDX_KI_MIX)) begin
        r_next.ki_coarse = 16'h0000; // [RULE_02]
        r_next.ki_fine = (pwdata > 32'(KI_MIX_MAX)) ? 16'(KI_MIX_MAX) :
                         pwdata[15:0]; // [RULE_02]
      end else if (hit(paddr, IDX_FB_FILT)) begin
        r_next.fb_filt = cap16(pwdata, FB_FILT_MAX); // [RULE_03]
      end else if (hit(paddr, IDX_FB_MODE)) begin
        r_next.fb_mode = pwdata[7:0];
      end else if (hit(paddr, IDX_INT_CLAMP)) begin
        r_next.int_clamp = (pwdata > 32'(INT_CLAMP_MAX)) ? 16'h8000 :
                           pwdata[15:0]; // [RULE_09]
      end else if (hit(paddr, IDX_OUT_FILT)) begin
        r_next.out_filt = pwdata[15:0];
      end else if (hit(paddr, IDX_OP_MODE)) begin
        r_next.op_mode = pwdata[7:0];
      end else if (hit(paddr, IDX_RAMP_STEP)) begin
        r_next.ramp_step = pwdata[15:0];
      end
    end
    // ---- pin synchroniser, second stage is the only reader
    r_next.sync1 = integ_off_pin;
    r_next.sync2 = r_reg.sync1;
    // ---- sample timer
    // a switch to fast cuts the running interval short, a switch to slow stretches it
    cyc_lim = fast ? 12'(CYC_FAST) : 12'(CYC_SLOW); // [RULE_06] [RULE_07]
    r_next.vtick = 1'b0;
    r_next.ptick = 1'b0;
    if (r_reg.cnt >= cyc_lim - 12'h001) begin
      r_next.cnt = 12'h000;
      r_next.vtick = 1'b1;
      r_next.pdiv = r_reg.pdiv + 2'b01;
      r_next.ptick = (r_reg.pdiv == 2'(POS_DIV - 1)); // [RULE_06] [RULE_07]
    end else begin
      r_next.cnt = r_reg.cnt + 12'h001;
    end
    // ---- loop arithmetic
    err_v = (SW+1)'(cmd_val) - (SW+1)'(fb_val); // [RULE_14]
    p_term = (48'(err_v) * $signed({32'h00000000, r_reg.kvp})) >>> P_SHIFT;
    i_sum = 48'(r_reg.integ) +
            ((48'(err_v) * $signed({31'h00000000, ki_mix})) >>> I_SHIFT);
    gap = (SW+1)'(speed_target) - (SW+1)'(r_reg.cmd);
    step_v = (SW+1)'($signed({1'b0, r_reg.ramp_step[SW-2:0]}));
    t_sum = p_term + 48'(r_reg.integ);
    if (r_reg.vtick) begin
      // otherwise the command slews by at most ramp_step per sample
      if (r_reg.op_mode == OP_NO_RAMP) begin
        r_next.cmd = speed_target; // [RULE_10]
      end else if (gap > step_v) begin
        r_next.cmd = SW'((SW+1)'(r_reg.cmd) + step_v);
      end else if (gap < -step_v) begin
        r_next.cmd = SW'((SW+1)'(r_reg.cmd) - step_v);
      end else begin
        r_next.cmd = speed_target;
      end
      // integral drops to zero while the pin holds it off
      if (r_reg.sync2) begin
        r_next.integ = 32'sh00000000; // [RULE_11]
      end else begin
        r_next.integ = sat(i_sum, {1'b0, r_reg.int_clamp}); // [RULE_09]
      end
      // saturate before narrowing so a large error cannot wrap the sign
      r_next.torque_raw = SW'(sat(t_sum, 17'h07FFF)); // [RULE_14]
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // parameters wake up at their defaults, loop state at zero
      r_reg <= '0;
      r_reg.kvp <= KVP_RST;
      r_reg.ki_coarse <= KI_COARSE_RST;
      r_reg.ki_fine <= KI_FINE_RST;
      r_reg.fb_filt <= FB_FILT_RST;
      r_reg.fb_mode <= FB_MODE_RST;
      r_reg.int_clamp <= INT_CLAMP_RST;
      r_reg.out_filt <= OUT_FILT_RST;
      r_reg.op_mode <= OP_MODE_RST;
      r_reg.ramp_step <= RAMP_STEP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero wait states: the answer is due in the first access cycle
  assign pready = psel && penable;
  assign prdata = r_reg.rdata;
  assign pslverr = psel && penable && r_reg.err;
  assign torque_cmd = outf_y; // [RULE_08]
  assign vel_tick = r_reg.vtick;
  assign pos_tick = r_reg.ptick;
endmodule

// *** include/ssl_pkg.sv ***
// Purpose: constants for the speed loop regulator
// Assumes: 32-bit apb, one word per register, byte address = index * 4
// Notes: indices are register numbers, not byte addresses
package ssl_pkg;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [23:0] IDX_KVP = 24'h60F901;
  localparam logic [23:0] IDX_KI_COARSE = 24'h60F902;
  localparam logic [23:0] IDX_FB_FILT = 24'h60F905;
  localparam logic [23:0] IDX_FB_MODE = 24'h60F906;
  localparam logic [23:0] IDX_KI_FINE = 24'h60F907;
  localparam logic [23:0] IDX_INT_CLAMP = 24'h60F908;
  localparam logic [23:0] IDX_OUT_FILT = 24'h60F915;
  localparam logic [23:0] IDX_KI_MIX = 24'h2FF019;
  localparam logic [23:0] IDX_OP_MODE = 24'h606000;
  localparam logic [23:0] IDX_RAMP_STEP = 24'h606001;
  localparam logic [23:0] IDX_STATUS = 24'h606002;
  localparam logic [23:0] IDX_TORQUE = 24'h606003;
  // ----------------------------------------
  // reset values and ranges
  // ----------------------------------------
  localparam logic [15:0] KVP_RST = 16'h0064;
  localparam logic [15:0] KI_COARSE_RST = 16'h0000;
  localparam logic [15:0] KI_FINE_RST = 16'h0000;
  localparam logic [15:0] FB_FILT_RST = 16'h0007;
  localparam logic [7:0] FB_MODE_RST = 8'h00;
  localparam logic [15:0] INT_CLAMP_RST = 16'h4000;
  localparam logic [15:0] OUT_FILT_RST = 16'h0001;
  localparam logic [7:0] OP_MODE_RST = 8'h00;
  localparam logic [15:0] RAMP_STEP_RST = 16'h0010;
  localparam logic [15:0] FB_FILT_MAX = 16'h002D;
  localparam logic [15:0] KI_COARSE_MAX = 16'h03FF;
  localparam logic [15:0] KI_FINE_MAX = 16'h7FFF;
  localparam logic [16:0] KI_MIX_MAX = 17'h04000;
  localparam logic [16:0] INT_CLAMP_MAX = 17'h08000;
  localparam logic [15:0] KVP_MAX = 16'h7FFF;
  localparam logic [7:0] OP_NO_RAMP = 8'hFD;
  // ----------------------------------------
  // fields and arithmetic
  // ----------------------------------------
  localparam int KI_COARSE_SHIFT = 5;
  localparam int FAST_RATE_BIT = 7;
  localparam logic [15:0] FB_BW_BASE = 16'h0064;
  localparam logic [15:0] FB_BW_STEP = 16'h0014;
  localparam int P_SHIFT = 8;
  localparam int I_SHIFT = 12;
  localparam int COEF_SHIFT = 16;
  localparam int POS_DIV = 4;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int VEL_TS_SLOW_NS = 250000;
  localparam int VEL_TS_FAST_NS = 125000;
  localparam int CYC_SLOW = VEL_TS_SLOW_NS / CLK_PERIOD_NS;
  localparam int CYC_FAST = VEL_TS_FAST_NS / CLK_PERIOD_NS;
  // coefficient per hertz in q16: 2*pi*ts*65536
  localparam longint TWO_PI_MILLI = 6283;
  localparam longint K_SLOW = TWO_PI_MILLI * VEL_TS_SLOW_NS * 65536 / 64'd1000000000000;
  localparam longint K_FAST = TWO_PI_MILLI * VEL_TS_FAST_NS * 65536 / 64'd1000000000000;
  typedef enum logic [1:0] {SSL_FB_LPF2, SSL_FB_RAW, SSL_FB_OBS, SSL_FB_LPF1} ssl_fb_e;
endpackage

// *** logic/ssl_lpf.sv ***
// Purpose: first-order low-pass stage, one update per enable pulse
// Assumes: coef is alpha in q16, caller keeps it below one
// Notes: output is registered
`timescale 1ns/1ps
module ssl_lpf
  import ssl_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [15:0] coef,
  input wire logic signed [W-1:0] x,
  output logic signed [W-1:0] y
);
  typedef struct packed {
    logic signed [W-1:0] y;
  } ssl_lpf_s;
  ssl_lpf_s r_reg, r_next;
  logic signed [W:0] diff;
  logic signed [W+17:0] prod;
  always_comb begin
    r_next = r_reg;
    diff = (W+1)'(x) - (W+1)'(r_reg.y);
    prod = (W+18)'(diff) * $signed({2'b00, coef});
    if (en) begin
      r_next.y = r_reg.y + W'(prod >>> COEF_SHIFT);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign y = r_reg.y;
endmodule

// *** bench/ssl_speed_loop_sva.sv ***
// Purpose: port-level checks of the speed loop regulator
// Assumes: single pclk domain, presetn async active low
// Notes: sample rate tracked from apb writes of the mode register
`timescale 1ns/1ps
module ssl_speed_loop_sva
  import ssl_pkg::*;
#(
  parameter int SW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic signed [SW-1:0] torque_cmd,
  input wire logic vel_tick,
  input wire logic pos_tick
);
  // ----------------------------------------
  // rate tracking
  // ----------------------------------------
  logic fast_reg, moved_reg, vseen_reg, pseen_reg, mode_wr;
  logic [11:0] gap_reg;
  logic [2:0] vcnt_reg;
  assign mode_wr = psel && penable && pwrite && paddr == {6'h00, IDX_FB_MODE, 2'h0};
  // interval spanning a mode write is skipped, rate may switch mid-interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_reg <= 1'b0;
      moved_reg <= 1'b0;
      vseen_reg <= 1'b0;
      pseen_reg <= 1'b0;
      gap_reg <= 12'h001;
      vcnt_reg <= 3'h0;
    end else begin
      moved_reg <= mode_wr || (moved_reg && !vel_tick);
      if (mode_wr) begin
        fast_reg <= pwdata[FAST_RATE_BIT];
      end
      gap_reg <= vel_tick ? 12'h001 : gap_reg + 12'h001;
      if (vel_tick) begin
        vseen_reg <= 1'b1;
        pseen_reg <= pseen_reg || pos_tick;
        vcnt_reg <= pos_tick ? 3'h0 : vcnt_reg + 3'h1;
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  AST_ZERO_WAIT: assert property (setup_s ##1 access_s |-> pready)
    else $error("pready missing in access cycle");
  AST_READY_ONLY: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_ERR_ONLY: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  AST_ERR_READ_ZERO: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_PRDATA_HOLD: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("prdata moved outside setup");
  AST_TORQUE_HOLD: assert property ($changed(torque_cmd) |-> $past(vel_tick))
    else $error("torque changed between samples");
  AST_TICK_PULSE: assert property (vel_tick |=> !vel_tick)
    else $error("velocity tick longer than one cycle");
  AST_POS_WITH_VEL: assert property (pos_tick |-> vel_tick)
    else $error("position tick without velocity tick");
  AST_POS_FOURTH: assert property (vel_tick && pseen_reg |-> pos_tick == (vcnt_reg == 3'h3))
    else $error("position tick not every fourth");
  AST_VEL_PERIOD: assert property (vel_tick && vseen_reg && !moved_reg |->
    gap_reg == (fast_reg ? CYC_FAST : CYC_SLOW))
    else $error("velocity sample period wrong");
  AST_VEL_NO_STALL: assert property (gap_reg <= CYC_SLOW + 2)
    else $error("velocity tick overdue");
endmodule

bind ssl_speed_loop ssl_speed_loop_sva #(.SW(SW)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .torque_cmd(torque_cmd), .vel_tick(vel_tick), .pos_tick(pos_tick)
);

// *** bench/test_ssl_speed_loop.sv ***
// Purpose: self-checking bench for the speed loop regulator
// Assumes: zero-wait apb slave, 10 MHz pclk
// Notes: loop checks allow a few lsb of filter residue
`timescale 1ns/1ps
module test_ssl_speed_loop
  import ssl_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, integ_off_pin, pready, pslverr;
  logic vel_tick, pos_tick, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic signed [15:0] speed_target, speed_raw, speed_observer, torque_cmd;
  int fail_count, total_checks, pos_seen, gap;
  logic [23:0] rst_idx [5] = '{IDX_FB_FILT, IDX_FB_MODE, IDX_OUT_FILT, IDX_KI_MIX, IDX_INT_CLAMP};
  logic [31:0] rst_val [5] = '{32'h7, 32'h0, 32'h1, 32'h0, 32'h4000};
  logic [7:0] modes [8] = '{8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h00, 8'h01, 8'h02, 8'h04};

  ssl_speed_loop dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .speed_target(speed_target), .speed_raw(speed_raw), .speed_observer(speed_observer),
    .integ_off_pin(integ_off_pin), .torque_cmd(torque_cmd), .vel_tick(vel_tick),
    .pos_tick(pos_tick)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic miss(input string msg);
    fail_count++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miss($sformatf("%s got %h want %h", what, got, exp));
    end
  endtask
  // torque sampled mid-cycle so the tick edge update has landed
  task automatic rng(input int lo, input int hi, input string what);
    @(negedge pclk);
    total_checks++;
    if ((torque_cmd >= lo && torque_cmd <= hi) !== 1'b1) begin
      miss($sformatf("%s torque %0d", what, torque_cmd));
    end
    @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [23:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {6'h00, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miss("apb timeout");
      end_of_test();
    end
  endtask
  task automatic wr(input logic [23:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rchk(input logic [23:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, $sformatf("reg %h", idx));
  endtask
  task automatic ticks(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (vel_tick !== 1'b1 && n < 3000);
      if (vel_tick !== 1'b1) begin
        miss("no velocity tick");
        end_of_test();
      end
      pos_seen += (pos_tick === 1'b1);
    end
    gap = n;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, integ_off_pin} = 5'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    speed_target = 16'h0000;
    speed_raw = 16'h0000;
    speed_observer = 16'h0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_idx[i]) rchk(rst_idx[i], rst_val[i]);
    wr(IDX_KI_COARSE, 32'h3);
    wr(IDX_KI_FINE, 32'h5);
    rchk(IDX_KI_MIX, 32'h65);
    wr(IDX_KI_MIX, 32'h4000);
    rchk(IDX_KI_COARSE, 32'h0);
    rchk(IDX_KI_FINE, 32'h4000);
    wr(IDX_KI_COARSE, 32'h3FF);
    rchk(IDX_KI_COARSE, 32'h3FF);
    wr(IDX_KI_FINE, 32'h7FFF);
    rchk(IDX_KI_MIX, 32'hFFDF);
    wr(IDX_FB_FILT, 32'h2D);
    rchk(IDX_FB_FILT, 32'h2D);
    wr(IDX_FB_FILT, 32'h2E);
    rchk(IDX_FB_FILT, 32'h2D);
    wr(IDX_INT_CLAMP, 32'h8000);
    rchk(IDX_INT_CLAMP, 32'h8000);
    wr(IDX_OUT_FILT, 32'h55A);
    rchk(IDX_OUT_FILT, 32'h55A);
    // back to pass-through so the loop checks see the unfiltered torque
    wr(IDX_OUT_FILT, 32'h1);
    apb(1'b0, 24'h123456, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    for (int i = 0; i < 8; i++) begin
      wr(IDX_FB_MODE, {24'h0, modes[i]});
      rchk(IDX_FB_MODE, {24'h0, modes[i]});
      apb(1'b0, IDX_STATUS, 32'h0);
      chk({31'h0, rd[2]}, {31'h0, i < 4}, "command filter");
    end
    wr(IDX_FB_MODE, 32'h1);
    ticks(2);
    chk(gap, CYC_SLOW, "slow period");
    pos_seen = 0;
    ticks(8);
    chk(pos_seen, 2, "slow position ticks");
    wr(IDX_FB_MODE, 32'h81);
    ticks(2);
    chk(gap, CYC_FAST, "fast period");
    pos_seen = 0;
    ticks(8);
    chk(pos_seen, 2, "fast position ticks");
    wr(IDX_KVP, 32'h100);
    wr(IDX_KI_MIX, 32'h0);
    speed_target <= 16'h03E8;
    speed_observer <= 16'h03E8;
    ticks(3);
    rng(1, 48, "ramped");
    wr(IDX_OP_MODE, 32'hFD);
    ticks(4);
    rng(990, 1000, "raw no ramp");
    wr(IDX_FB_MODE, 32'h82);
    ticks(4);
    rng(-2, 2, "observer");
    wr(IDX_FB_MODE, 32'h81);
    wr(IDX_KVP, 32'h0);
    wr(IDX_INT_CLAMP, 32'h10);
    wr(IDX_KI_COARSE, 32'h3FF);
    ticks(6);
    rng(14, 16, "clamped");
    integ_off_pin <= 1'b1;
    ticks(6);
    rng(-1, 1, "integral off");
    integ_off_pin <= 1'b0;
    ticks(6);
    rng(14, 16, "integral back");
    wr(IDX_OUT_FILT, 32'h2);
    integ_off_pin <= 1'b1;
    ticks(3);
    rng(6, 8, "torque filter halves a step");
    end_of_test();
  end
endmodule
